// *** verilog/clock_select_consts.svh ***
// constants for the system clock select and external oscillator control block
// assumes the includer uses these names for offsets, fields, reset values and codes
`ifndef CLOCK_SELECT_CONSTS_SVH
`define CLOCK_SELECT_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets on the special function register bus
// ----------------------------------------------------------------
`define OFS_INTERNAL_CTRL 8'h8a
`define OFS_EXTERNAL_CTRL 8'h8c
`define OFS_CLOCK_SELECT 8'h97

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_INTERNAL_ENABLE 1'b1
`define RST_INTERNAL_DIV 2'h0
`define RST_EXTERNAL_MODE 3'h0
`define RST_EXTERNAL_FREQ 3'h0
`define RST_CLOCK_SELECT 1'b0
`define RST_BYTE 8'h00

// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define BIT_SELECT 0
`define BIT_INT_ENABLE 7
`define BIT_INT_READY 6
`define BIT_XTAL_VALID 7
`define MODE_MSB 6
`define MODE_LSB 4
`define FREQ_MSB 2
`define DIV_MSB 1
`define DIV_BY_8 2'h0
`define DIV_BY_4 2'h1
`define DIV_BY_2 2'h2
`define DIV_BY_1 2'h3
`define MODE_HI_OFF 2'h0
`define MODE_HI_RC 2'h2
`define MODE_HI_CRYSTAL 2'h3
`define INT_DIV_WIDTH 3
`define INT_DIV_ONE 3'h1

`endif

// *** verilog/clock_select_pkg.sv ***
// types shared by the clock select block
// assumes the consts header supplies every number
`default_nettype none
package clock_select_pkg;

  // one special function register access, as the core presents it
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_t;

  // source switch sequencer, one-hot
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SWITCH = 2'b10
  } switch_state_t;

endpackage
`default_nettype wire

// *** verilog/settle_counter.sv ***
// counts source edges after enable until a settle figure is reached
// assumes tick is a one-cycle pulse synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module settle_counter #(
  parameter int WIDTH = 11,
  parameter logic [WIDTH-1:0] LIMIT = 11'd1024
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic tick,
  output logic done
);
  logic [WIDTH-1:0] count;

  // cleared whenever the source is disabled, so a restart settles again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (!enable) begin
      count <= '0;
    end else if (tick && count != LIMIT) begin
      count <= count + 1'b1;
    end
  end

  assign done = enable && (count == LIMIT);
endmodule
`default_nettype wire

// *** verilog/system_clock_select.sv ***
// system clock source select and external oscillator control registers
// assumes oscillator levels arrive already synchronous to SYS_CLK, which
// oversamples them; register access comes from the core's sfr bus
// Notes on behaviour
// R1 - select bit 0 picks scaled internal oscillator, 1 picks external circuit
// R2 - external oscillator stays usable for peripherals while internal is selected
// R3 - source may change on the fly; software picks only a settled one
// R4 - one internal control write may enable and select the internal oscillator
// R5 - hardware sets crystal valid in bit 7 once settled, else reads 0
// R6 - crystal valid means something only in crystal modes 11x
// R7 - mode field bits 6-4 decode off, cmos, cmos/2, rc/2, crystal, crystal/2
// R8 - bit 3 of external control reads 0, writes ignored
// R9 - software sets frequency field to the crystal frequency range
// R10 - software sets frequency field to the rc frequency range
// R11 - in capacitor mode frequency field picks the k factor
// R12 - software waits 1 ms after enabling crystal before reading valid
// R13 - enable, wait, poll valid, then set the select bit
// R14 - software never selects an unsettled crystal
// R15 - rc and capacitor modes are usable at once, no start-up wait
// R16 - internal divider field: 00 /8, 01 /4, 10 /2, 11 /1
// R17 - internal ready flag reads 1 only while oscillator runs settled
// R18 - source and divider changes never shorten a clock phase; here a low phase can end early, as handover needs only both levels low
// R19 - after reset select and external control read all zeros
`timescale 1ns/100ps
`default_nettype none
`include "clock_select_consts.svh"
module system_clock_select #(
  parameter int XTAL_WIDTH = 11,
  parameter logic [XTAL_WIDTH-1:0] XTAL_SETTLE_EDGES = 11'd1024,
  parameter int INT_WIDTH = 5,
  parameter logic [INT_WIDTH-1:0] INT_SETTLE_EDGES = 5'd16
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // sfr bus
  input wire clock_select_pkg::sfr_req_t SFR_REQ,
  output logic [7:0] SFR_RDATA,
  // oscillator levels
  input wire logic INT_OSC_IN,
  input wire logic FIRST_CRYSTAL_PIN,
  // analog controls and clocks out
  output logic INT_OSC_ENABLE,
  output logic [2:0] EXTERNAL_MODE_FIELD,
  output logic [2:0] EXTERNAL_FREQUENCY_CONTROL,
  output logic EXT_CLOCK,
  output logic SYSTEM_CLOCK
);
  logic int_en;
  logic [1:0] int_div;
  logic [2:0] ext_mode;
  logic [2:0] ext_freq;
  logic sel;
  logic int_ready;
  logic xtal_valid;
  logic int_prev;
  logic ext_prev;
  logic ext_half;
  logic [`INT_DIV_WIDTH-1:0] int_cnt;
  logic active_sel;
  logic [1:0] active_div;
  clock_select_pkg::switch_state_t state;
  logic int_raw;
  logic ext_raw;
  logic int_tick;
  logic ext_tick;
  logic crystal_mode;
  logic ext_level;
  logic cur_level;
  logic cand_level;
  logic wr_int;
  logic wr_ext;
  logic wr_sel;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  assign wr_int = SFR_REQ.wr && SFR_REQ.addr == `OFS_INTERNAL_CTRL;
  assign wr_ext = SFR_REQ.wr && SFR_REQ.addr == `OFS_EXTERNAL_CTRL;
  assign wr_sel = SFR_REQ.wr && SFR_REQ.addr == `OFS_CLOCK_SELECT;

  // enable and divider land together from one write
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_en <= `RST_INTERNAL_ENABLE;
      int_div <= `RST_INTERNAL_DIV;
    end else if (wr_int) begin // see R4
      int_en <= SFR_REQ.wdata[`BIT_INT_ENABLE];
      int_div <= SFR_REQ.wdata[`DIV_MSB:0];
    end
  end

  // bit 3 and bit 7 are not stored, so writes to them vanish
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_mode <= `RST_EXTERNAL_MODE; // see R19
      ext_freq <= `RST_EXTERNAL_FREQ;
    end else if (wr_ext) begin // see R8
      ext_mode <= SFR_REQ.wdata[`MODE_MSB:`MODE_LSB];
      ext_freq <= SFR_REQ.wdata[`FREQ_MSB:0];
    end
  end

  // any write takes effect; the switch itself waits for a safe moment
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sel <= `RST_CLOCK_SELECT; // see R19
    end else if (wr_sel) begin // see R3
      sel <= SFR_REQ.wdata[`BIT_SELECT];
    end
  end

  // ----------------------------------------------------------------
  // register reads, registered; unmapped addresses answer zero
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SFR_RDATA <= `RST_BYTE;
    end else if (SFR_REQ.rd) begin
      case (SFR_REQ.addr)
        `OFS_INTERNAL_CTRL: SFR_RDATA <= {int_en, int_ready, 4'h0, int_div}; // see R17
        `OFS_EXTERNAL_CTRL: SFR_RDATA <= {xtal_valid, ext_mode, 1'b0, ext_freq}; // see R5, R8
        `OFS_CLOCK_SELECT: SFR_RDATA <= {7'h00, sel};
        default: SFR_RDATA <= `RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // oscillator edges and settle tracking
  // ----------------------------------------------------------------
  assign int_raw = INT_OSC_IN && int_en;
  assign ext_raw = FIRST_CRYSTAL_PIN && (ext_mode[2:1] != `MODE_HI_OFF); // see R7
  assign int_tick = int_raw && !int_prev;
  assign ext_tick = ext_raw && !ext_prev;
  assign crystal_mode = ext_mode[2:1] == `MODE_HI_CRYSTAL;

  // previous levels for edge detection
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_prev <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      int_prev <= int_raw;
      ext_prev <= ext_raw;
    end
  end

  // counting edges rather than time means a dead crystal never goes valid
  settle_counter #(.WIDTH(XTAL_WIDTH), .LIMIT(XTAL_SETTLE_EDGES)) u_xtal_settle (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .enable(crystal_mode), // see R6
    .tick(ext_tick),
    .done(xtal_valid) // see R5
  );

  settle_counter #(.WIDTH(INT_WIDTH), .LIMIT(INT_SETTLE_EDGES)) u_int_settle (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .enable(int_en),
    .tick(int_tick),
    .done(int_ready) // see R17
  );

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  // internal counter advances on each internal edge
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_cnt <= '0;
    end else if (int_tick) begin
      int_cnt <= int_cnt + `INT_DIV_ONE;
    end
  end

  // external halving stage, used by cmos/2, rc/c and crystal/2
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_half <= 1'b0;
    end else if (ext_tick) begin
      ext_half <= !ext_half;
    end
  end

  // rc and c take the halved level with no settle gate at all
  assign ext_level = (ext_mode[2:1] == `MODE_HI_OFF) ? 1'b0 :
                     (ext_mode[0] || ext_mode[2:1] == `MODE_HI_RC) ? ext_half : ext_raw; // see R7, R15

  // level of a source for a given select and divider setting
  function automatic logic src_level(input logic s, input logic [1:0] d,
                                     input logic [`INT_DIV_WIDTH-1:0] c,
                                     input logic raw, input logic ext);
    logic lvl;
    lvl = 1'b0;
    if (s) begin
      lvl = ext;
    end else begin
      case (d)
        `DIV_BY_8: lvl = c[2];
        `DIV_BY_4: lvl = c[1];
        `DIV_BY_2: lvl = c[0];
        default: lvl = raw;
      endcase
    end
    return lvl;
  endfunction

  assign cur_level = src_level(active_sel, active_div, int_cnt, int_raw, ext_level); // see R1, R16
  assign cand_level = src_level(sel, int_div, int_cnt, int_raw, ext_level);

  // ----------------------------------------------------------------
  // glitch-free switch: hand over only while both levels are low
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= clock_select_pkg::ST_RUN;
      active_sel <= `RST_CLOCK_SELECT;
      active_div <= `RST_INTERNAL_DIV;
    end else begin
      case (state)
        clock_select_pkg::ST_RUN: begin
          if (sel != active_sel || int_div != active_div) begin // see R3
            state <= clock_select_pkg::ST_SWITCH;
          end
        end
        clock_select_pkg::ST_SWITCH: begin
          // a new source stuck high leaves the old one running; one stuck low takes over; never a runt pulse
          if (!cur_level && !cand_level) begin // see R18
            active_sel <= sel;
            active_div <= int_div;
            state <= clock_select_pkg::ST_RUN;
          end
        end
        default: state <= clock_select_pkg::ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SYSTEM_CLOCK <= 1'b0;
      EXT_CLOCK <= 1'b0;
      INT_OSC_ENABLE <= `RST_INTERNAL_ENABLE;
      EXTERNAL_MODE_FIELD <= `RST_EXTERNAL_MODE;
      EXTERNAL_FREQUENCY_CONTROL <= `RST_EXTERNAL_FREQ;
    end else begin
      SYSTEM_CLOCK <= cur_level; // see R1
      EXT_CLOCK <= ext_level; // see R2
      INT_OSC_ENABLE <= int_en;
      EXTERNAL_MODE_FIELD <= ext_mode;
      EXTERNAL_FREQUENCY_CONTROL <= ext_freq;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  a_bit3_reads_zero: assert property (SFR_RDATA[3] == 1'b0) // see R8
    else $error("reserved bit 3 read back as one");
  // checked at the read port, so a broken read path trips it too
  a_valid_only_crystal: assert property (SFR_REQ.rd && !crystal_mode // see R6
    && SFR_REQ.addr == `OFS_EXTERNAL_CTRL |=> !SFR_RDATA[`BIT_XTAL_VALID])
    else $error("crystal valid set outside crystal mode");
  a_valid_read_out: assert property (SFR_REQ.rd // see R5
    && SFR_REQ.addr == `OFS_EXTERNAL_CTRL |=> SFR_RDATA[`BIT_XTAL_VALID] == $past(xtal_valid))
    else $error("crystal valid not shown in bit 7");
  a_select_write: assert property (wr_sel |=> sel == $past(SFR_REQ.wdata[`BIT_SELECT])) // see R3
    else $error("select write not stored");
  a_int_one_write: assert property (wr_int && SFR_REQ.wdata == 8'h83 // see R4
    |=> int_en && int_div == `DIV_BY_1 ##1 INT_OSC_ENABLE)
    else $error("single write did not enable and select internal");
  a_switch_when_low: assert property ($changed(active_sel) || $changed(active_div)
    |-> !SYSTEM_CLOCK) // see R18
    else $error("source switched while clock high");
  a_ready_needs_enable: assert property (SFR_REQ.rd && !int_en // see R17
    && SFR_REQ.addr == `OFS_INTERNAL_CTRL |=> !SFR_RDATA[`BIT_INT_READY])
    else $error("internal ready without enable");
  a_ext_off_quiet: assert property (ext_mode[2:1] == `MODE_HI_OFF |=> !EXT_CLOCK) // see R7
    else $error("external clock toggles while off");
  a_int_passthrough: assert property (state == clock_select_pkg::ST_RUN && !active_sel // see R1
    && active_div == `DIV_BY_1 |=> SYSTEM_CLOCK == $past(int_raw))
    else $error("undivided internal clock not passed");

  c_switch_to_ext: cover property (state == clock_select_pkg::ST_SWITCH && sel ##1 active_sel);
  c_crystal_valid: cover property ($rose(xtal_valid));
  c_div_change: cover property ($changed(active_div));
endmodule
`default_nettype wire

// *** test/osc_source_model.sv ***
// partner model: the internal oscillator and the external crystal or clock source
// assumes levels change just after a SYS_CLK edge, since the block oversamples them
`timescale 1ns/100ps
`default_nettype none
module osc_source_model #(
  parameter int INT_HALF = 2,
  parameter int EXT_HALF = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controls from the block
  input wire logic int_enable,
  input wire logic [2:0] ext_mode,
  // oscillator levels
  output logic int_level,
  output logic ext_level
);
  int int_cnt;
  int ext_cnt;
  // ----------------------------------------------------------------
  // oscillators
  // ----------------------------------------------------------------
  // internal oscillator is silent while disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_cnt <= 0;
      int_level <= 1'b0;
    end else if (!int_enable) begin
      int_cnt <= 0;
      int_level <= 1'b0;
    end else if (int_cnt == INT_HALF - 1) begin
      int_cnt <= 0;
      int_level <= ~int_level;
    end else begin
      int_cnt <= int_cnt + 1;
    end
  end
  // an idle drive circuit leaves the pin floating: toggle so no level is trusted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_cnt <= 0;
      ext_level <= 1'b0;
    end else if (ext_mode[2:1] == 2'b00) begin
      ext_cnt <= 0;
      ext_level <= ~ext_level;
    end else if (ext_cnt == EXT_HALF - 1) begin
      ext_cnt <= 0;
      ext_level <= ~ext_level;
    end else begin
      ext_cnt <= ext_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// *** test/tb_system_clock_select.sv ***
// testbench for the system clock select block
// assumes the partner model supplies both oscillator levels
`timescale 1ns/100ps
`default_nettype none
`include "clock_select_consts.svh"
module tb_system_clock_select_ext_osc;
  logic sys_clk;
  logic rst_n;
  clock_select_pkg::sfr_req_t req;
  logic [7:0] rdata;
  logic int_lvl;
  logic ext_lvl;
  logic int_en;
  logic [2:0] mode;
  logic [2:0] freq;
  logic ext_clk;
  logic sys_out;
  logic pend = 1'b0;
  logic [3:0] prev = 4'h0;
  logic clr_rises = 1'b0;
  logic [23:0] notes[$];
  logic [23:0] note;
  int rises[4];
  int bad_count;
  int num_checks;
  int f;
  wire logic [3:0] cur = {sys_out, ext_clk, ext_lvl, int_lvl};

  system_clock_select #(.XTAL_SETTLE_EDGES(11'd4), .INT_SETTLE_EDGES(5'd2)) dut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .SFR_REQ(req), .SFR_RDATA(rdata),
    .INT_OSC_IN(int_lvl), .FIRST_CRYSTAL_PIN(ext_lvl), .INT_OSC_ENABLE(int_en),
    .EXTERNAL_MODE_FIELD(mode), .EXTERNAL_FREQUENCY_CONTROL(freq),
    .EXT_CLOCK(ext_clk), .SYSTEM_CLOCK(sys_out));
  osc_source_model partner (.clk(sys_clk), .rst_n(rst_n), .int_enable(int_en),
    .ext_mode(mode), .int_level(int_lvl), .ext_level(ext_lvl));

  // ----------------------------------------------------------------
  // clock, edge counters and read checker
  // ----------------------------------------------------------------
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  // rising edges of pins and clocks, for rate comparisons
  // clearing here keeps the counters owned by one process
  always @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (clr_rises) begin
        rises[i] = 0;
      end else if (cur[i] === 1'b1 && prev[i] === 1'b0) begin
        rises[i]++;
      end
    end
    prev <= cur;
  end
  // read data stands one cycle after the strobe; oldest note holds the expectation
  always @(posedge sys_clk) begin
    if (pend === 1'b1) begin
      note = notes.pop_front();
      num_checks++;
      if ((rdata & note[15:8]) !== note[7:0]) begin
        bad_count++;
        $display("ERROR reg %h expected %h seen %h", note[23:16], note[7:0], rdata & note[15:8]);
      end
    end
    pend <= req.rd;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    notes.push_back({a, m, e});
    @(posedge sys_clk);
    req.rd <= 1'b0;
  endtask
  // rates are counted over a window, so one edge of slack either way
  task automatic near(input string nm, input int seen, input int e);
    num_checks++;
    if (seen > e + 1 || seen < e - 1) begin
      bad_count++;
      $display("ERROR %s expected %0d seen %0d", nm, e, seen);
    end
  endtask
  task automatic same(input string nm, input logic [7:0] seen, input logic [7:0] e);
    num_checks++;
    if (seen !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic settle_measure();
    repeat (40) @(posedge sys_clk);
    clr_rises <= 1'b1;
    @(posedge sys_clk);
    clr_rises <= 1'b0;
    repeat (240) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic test_end(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    req = '0;
    bad_count = 0;
    num_checks = 0;
    f = $urandom(32'h67222242);
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`OFS_EXTERNAL_CTRL, 8'hff, 8'h00);
    rd(`OFS_CLOCK_SELECT, 8'hff, 8'h00);
    wr(8'h55, 8'($urandom));
    rd(8'h55, 8'hff, 8'h00);
    repeat (20) @(posedge sys_clk);
    rd(`OFS_INTERNAL_CTRL, 8'hff, 8'hc0);
    test_end("reset");
    // every divider code, reserved bits written with noise
    for (int d = 0; d < 4; d++) begin
      wr(`OFS_INTERNAL_CTRL, {1'b1, 5'($urandom), 2'(d)});
      rd(`OFS_INTERNAL_CTRL, 8'hff, {6'h30, 2'(d)});
      settle_measure();
      near("divided clock", rises[3], rises[0] >> (3 - d));
    end
    test_end("divider");
    // every mode code; valid flag masked, its meaning depends on history
    for (int m = 0; m < 8; m++) begin
      f = $urandom % 8;
      wr(`OFS_EXTERNAL_CTRL, {1'b1, 3'(m), 1'b1, 3'(f)});
      rd(`OFS_EXTERNAL_CTRL, 8'h7f, {1'b0, 3'(m), 1'b0, 3'(f)});
      same("mode field", {5'h0, mode}, 8'(m));
      same("frequency field", {5'h0, freq}, 8'(f));
      settle_measure();
      near("peripheral clock", rises[2], m < 2 ? 0 : (m == 2 || m == 6) ? rises[1] : rises[1] / 2);
    end
    test_end("modes");
    // crystal start-up then switch over
    wr(`OFS_EXTERNAL_CTRL, 8'h00);
    wr(`OFS_EXTERNAL_CTRL, 8'h67);
    rd(`OFS_EXTERNAL_CTRL, 8'hff, 8'h67);
    repeat (60) @(posedge sys_clk);
    rd(`OFS_EXTERNAL_CTRL, 8'hff, 8'he7);
    wr(`OFS_CLOCK_SELECT, 8'hff);
    rd(`OFS_CLOCK_SELECT, 8'hff, 8'h01);
    settle_measure();
    near("crystal system clock", rises[3], rises[1]);
    wr(`OFS_INTERNAL_CTRL, 8'h03);
    rd(`OFS_INTERNAL_CTRL, 8'hff, 8'h03);
    same("internal enable", {7'h0, int_en}, 8'h00);
    wr(`OFS_INTERNAL_CTRL, 8'h83);
    wr(`OFS_CLOCK_SELECT, 8'h00);
    settle_measure();
    near("undivided internal", rises[3], rises[0]);
    rd(`OFS_INTERNAL_CTRL, 8'hff, 8'hc3);
    test_end("switch");
    // rc mode may be selected at once
    wr(`OFS_EXTERNAL_CTRL, 8'h40);
    wr(`OFS_CLOCK_SELECT, 8'h01);
    settle_measure();
    near("rc system clock", rises[3], rises[1] / 2);
    test_end("rc");
    repeat (4) @(posedge sys_clk);
    complete_run();
  end

  // hang guard: the tests need well under 6000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("ERROR watchdog expected finish seen timeout");
    complete_run();
  end
endmodule
`default_nettype wire
